// [core/sic_pkg.sv]
// Constants and carrier types of the system integration block
package sic_pkg;
	localparam int          NCS       = 4;
	localparam logic [11:0] MAP_HI    = 12'hFFF;
	localparam logic [11:0] MAP_LO    = 12'h7FF;
	localparam logic [3:0]  ARB_RST   = 4'hF;
	localparam logic [7:0]  SVC_ARM   = 8'h55;
	localparam logic [7:0]  SVC_DONE  = 8'hAA;
	localparam logic [8:0]  PRESC_TOP = 9'h1FF;
	localparam int          WD_LOG2   = 9;
	localparam logic [6:0]  BM_BASE   = 7'h40;
	localparam logic [2:0]  SLOW_DIV8 = 3'h3;
	localparam logic [2:0]  SLOW_DIV16 = 3'h7;
	localparam logic [1:0]  PA_DISC   = 2'h0;
	localparam logic [1:0]  PA_ALT    = 2'h1;
	localparam logic [1:0]  PA_8BIT   = 2'h2;
	localparam logic [1:0]  PA_16BIT  = 2'h3;
	localparam logic [1:0]  FC_USER   = 2'h0;
	localparam logic [1:0]  FC_SUPER  = 2'h1;
	localparam logic [1:0]  FC_CPU    = 2'h3;
	localparam logic [1:0]  SP_CPU    = 2'h0;
	localparam logic [1:0]  SP_USER   = 2'h1;
	localparam logic [1:0]  SP_SUPER  = 2'h2;
	localparam logic [1:0]  SP_BOTH   = 2'h3;
	localparam logic [3:0]  ACK_FAST  = 4'hE;
	localparam logic [3:0]  ACK_EXT   = 4'hF;
	localparam logic [3:0]  BOOT_WAIT = 4'hD;
	localparam logic [2:0]  BLK_1M    = 3'h7;
	typedef enum logic [1:0] {SVC_IDLE = 2'h0, SVC_ARMED = 2'h1} sic_svc_t;
	typedef struct packed {
		logic       mapSel;
		logic       wdEn;
		logic [3:0] arb;
	} sic_ctrl_t;
	typedef struct packed {
		logic [1:0]  pa;
		logic [12:0] base;
		logic [2:0]  blk;
		logic        mode;
		logic [1:0]  byteSel;
		logic [1:0]  dir;
		logic        strobeSel;
		logic [3:0]  ack;
		logic [1:0]  space;
		logic [2:0]  level;
		logic        autoVec;
	} sic_cs_t;
	typedef struct packed {
		logic [23:0] addr;
		logic        as;
		logic        ds;
		logic        rd;
		logic        upper;
		logic        lower;
		logic [1:0]  space;
		logic        extAck;
	} sic_bus_t;
	localparam sic_ctrl_t CTRL_RST = '{mapSel: 1'b1, wdEn: 1'b1, arb: ARB_RST};
	localparam sic_cs_t BOOT_RST = '{pa: PA_16BIT, base: 13'h0000, blk: BLK_1M, mode: 1'b0,
		byteSel: 2'h3, dir: 2'h3, strobeSel: 1'b0, ack: BOOT_WAIT, space: SP_BOTH,
		level: 3'h0, autoVec: 1'b0};
	// Block sizes 2K,8K,16K,64K,128K,256K,512K,1M over addr[23:11]
	function automatic logic [12:0] blkMask(input logic [2:0] b);
		case (b)
			3'h0: blkMask = 13'h0000;
			3'h1: blkMask = 13'h0003;
			3'h2: blkMask = 13'h0007;
			3'h3: blkMask = 13'h001F;
			3'h4: blkMask = 13'h003F;
			3'h5: blkMask = 13'h007F;
			3'h6: blkMask = 13'h00FF;
			default: blkMask = 13'h01FF;
		endcase
	endfunction : blkMask
endpackage : sic_pkg

// [core/sic_top.sv]
// System integration block: configuration, timers, monitors, chip selects
`timescale 1ns/100ps
// Contract
// R01 - Map bit picks high or low register block
// R02 - Freeze halts timers or monitor when enabled
// R03 - Arbitration resets F; timer beats external
// R04 - Software gives unique non-zero arbitration values
// R05 - Three fields set synthesized clock frequency
// R06 - Crystal loss: reset or limp mode
// R07 - Stop selects running clocks; divider sets slow
// R08 - Watchdog on at reset, service or reset
// R09 - Bus monitor, timeout and double fault enables
// R10 - Nonzero modulus runs periodic timer; prescale option
// R11 - Zero level masks requests; vector on acknowledge
// R12 - Pin assignment: discrete, 8-bit, 16-bit, alternate
// R13 - Strobe needs select mode; autovector any mode
// R14 - Boot select: base zero, 1M, 13 waits
// R15 - Base aligned to its block size
// R16 - Acknowledge selects use base FFF8 or above
// R17 - Synchronous mode ignores strobe and acknowledge fields
// R18 - Byte lane and direction qualify assertion
// R19 - Strobe select: address or data strobe
// R20 - Wait count, external, fast autovector termination
// R21 - Space match; level match for acknowledge
// R22 - Autovector bit picks autovector or strobe only
// R23 - Assert only inside window, all conditions true
module sic_top #(
	parameter int         WD_LOG2   = sic_pkg::WD_LOG2,
	parameter logic [8:0] PRESC_TOP = sic_pkg::PRESC_TOP
) (
	input  wire logic                        mclk,
	input  wire logic                        rstn,
	input  wire logic                        ctrlWe,
	input  wire sic_pkg::sic_ctrl_t          ctrlWd,
	input  wire logic                        freeze,
	input  wire logic                        haltSoftwareTimersEnable,
	input  wire logic                        haltBusMonitorEnable,
	input  wire logic [1:0]                  synthW,
	input  wire logic                        synthX,
	input  wire logic [5:0]                  synthY,
	input  wire logic                        crystalLossResetEnable,
	input  wire logic                        crystalLost,
	input  wire logic                        lowPowerStop,
	input  wire logic                        stopSystemClockSelect,
	input  wire logic                        stopExternalClockSelect,
	input  wire logic                        slowClockDivider,
	input  wire logic                        watchdogPrescale,
	input  wire logic [1:0]                  watchdogTimeoutSelect,
	input  wire logic                        serviceWe,
	input  wire logic [7:0]                  serviceData,
	input  wire logic                        busMonitorEnable,
	input  wire logic [1:0]                  busMonitorTimeout,
	input  wire logic                        doubleFaultMonitorEnableA,
	input  wire logic                        doubleFaultMonitorEnableB,
	input  wire logic [7:0]                  periodicModulus,
	input  wire logic                        periodicPrescale,
	input  wire logic [2:0]                  periodicRequestLevel,
	input  wire logic [7:0]                  periodicVectorNumber,
	input  wire logic [sic_pkg::NCS-1:0]     csWe,
	input  wire sic_pkg::sic_cs_t            csWd,
	input  wire logic [sic_pkg::NCS-1:0]     portCData,
	input  wire sic_pkg::sic_bus_t           bus,
	output logic                             regSelect,
	output logic [3:0]                       arbitrationPriority,
	output logic [11:0]                      freqMult,
	output logic                             systemReset,
	output logic                             limpMode,
	output logic                             sysClockRun,
	output logic                             extClockRun,
	output logic                             slowPeripheralClockOut,
	output logic                             busError,
	output logic                             haltOut,
	output logic [2:0]                       periodicIrqLevel,
	output logic [7:0]                       vectorOut,
	output logic                             vectorValid,
	output logic [sic_pkg::NCS-1:0]          selectOutN,
	output logic [1:0]                       cycleAck,
	output logic                             autovectorRequest
);
	sic_pkg::sic_ctrl_t    ctrl_r;
	sic_pkg::sic_svc_t     svc_r;
	logic [8:0]            presc_r;
	logic [15:0]           wdCnt_r;
	logic [7:0]            perCnt_r;
	logic                  perPend_r;
	logic [6:0]            bmCnt_r;
	logic                  faultSeen_r;
	logic [2:0]            slowDiv_r;
	logic                  timersHalted, tick, wdStep, wdExpire, serviced;
	logic                  perStep, perEvent, intAckCycle, perWins;
	logic [2:0]            intAckLevel, slowMask;
	logic [15:0]           wdLimit;
	logic [6:0]            bmLimit;
	logic                  bmExpire, slowToggle, slowFall, anyAck;
	logic [sic_pkg::NCS-1:0] csAck8, csAck16, csAuto;

	assign timersHalted = freeze & haltSoftwareTimersEnable; // [R02]
	assign tick         = (presc_r == PRESC_TOP);
	assign wdStep       = ctrl_r.wdEn & ~timersHalted & (~watchdogPrescale | tick); // [R08]
	assign wdLimit      = 16'((32'h1 << (WD_LOG2 + 2 * int'(watchdogTimeoutSelect))) - 32'h1);
	assign wdExpire     = wdStep & (wdCnt_r == wdLimit); // [R08]
	assign serviced     = serviceWe & (svc_r == sic_pkg::SVC_ARMED)
		& (serviceData == sic_pkg::SVC_DONE);
	assign slowMask     = slowClockDivider ? sic_pkg::SLOW_DIV16 : sic_pkg::SLOW_DIV8;
	assign slowToggle   = ((slowDiv_r & slowMask) == slowMask);
	assign slowFall     = slowToggle & slowPeripheralClockOut;
	assign anyAck       = bus.extAck | (|csAck8) | (|csAck16) | (|csAuto);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctrl_r <= sic_pkg::CTRL_RST; // [R01] [R03] [R08]
		end else if (ctrlWe) begin
			ctrl_r <= ctrlWd;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			regSelect           <= 1'b0;
			arbitrationPriority <= sic_pkg::ARB_RST;
		end else begin
			regSelect <= bus.as & (bus.addr[23:12] ==
				(ctrl_r.mapSel ? sic_pkg::MAP_HI : sic_pkg::MAP_LO)); // [R01]
			arbitrationPriority <= ctrl_r.arb; // [R03]
		end
	end

	// Clock synthesizer controls
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			freqMult               <= 12'h000;
			limpMode               <= 1'b0;
			sysClockRun            <= 1'b1;
			extClockRun            <= 1'b1;
			slowDiv_r              <= 3'h0;
			slowPeripheralClockOut <= 1'b0;
		end else begin
			freqMult <= 12'({5'h00, 7'(synthY) + 7'h01}
				<< (2 + 2 * int'(synthW) + int'(synthX))); // [R05]
			limpMode    <= crystalLost & ~crystalLossResetEnable; // [R06]
			sysClockRun <= ~lowPowerStop | stopSystemClockSelect; // [R07]
			extClockRun <= ~lowPowerStop | stopExternalClockSelect; // [R07]
			if (~lowPowerStop | stopExternalClockSelect) begin
				slowDiv_r <= slowDiv_r + 3'h1;
				if (slowToggle) begin
					slowPeripheralClockOut <= ~slowPeripheralClockOut; // [R07]
				end
			end
		end
	end

	// Prescaler shared by watchdog and periodic timer
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			presc_r <= 9'h000;
		end else if (!timersHalted) begin
			presc_r <= tick ? 9'h000 : presc_r + 9'h001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			svc_r <= sic_pkg::SVC_IDLE;
		end else if (serviceWe) begin
			case (svc_r)
				sic_pkg::SVC_IDLE: begin
					svc_r <= (serviceData == sic_pkg::SVC_ARM) ? sic_pkg::SVC_ARMED
						: sic_pkg::SVC_IDLE;
				end
				sic_pkg::SVC_ARMED: begin
					svc_r <= (serviceData == sic_pkg::SVC_ARM) ? sic_pkg::SVC_ARMED
						: sic_pkg::SVC_IDLE;
				end
				default: svc_r <= sic_pkg::SVC_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wdCnt_r     <= 16'h0000;
			systemReset <= 1'b0;
		end else begin
			if (serviced | wdExpire) begin
				wdCnt_r <= 16'h0000; // [R08]
			end else if (wdStep) begin
				wdCnt_r <= wdCnt_r + 16'h0001;
			end
			systemReset <= wdExpire | (crystalLost & crystalLossResetEnable); // [R06] [R08]
		end
	end

	// Bus monitor; the count restarts on every termination except the periodic timer's own vector cycle
	assign bmLimit  = (sic_pkg::BM_BASE >> busMonitorTimeout) - 7'h01;
	assign bmExpire = busMonitorEnable & ~(freeze & haltBusMonitorEnable)
		& bus.as & (bmCnt_r == bmLimit); // [R02] [R09]

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bmCnt_r     <= 7'h00;
			busError    <= 1'b0;
			faultSeen_r <= 1'b0;
			haltOut     <= 1'b0;
		end else begin
			bmCnt_r  <= (~bus.as | anyAck | bmExpire) ? 7'h00 : bmCnt_r + 7'h01;
			busError <= bmExpire; // [R09]
			if (bmExpire) begin
				faultSeen_r <= 1'b1;
			end else if (anyAck) begin
				faultSeen_r <= 1'b0;
			end
			if (bmExpire & faultSeen_r
				& (doubleFaultMonitorEnableA | doubleFaultMonitorEnableB)) begin
				haltOut <= 1'b1; // [R09]
			end
		end
	end

	// Periodic timer; it owns its acknowledge ahead of external requests
	assign perStep     = (periodicModulus != 8'h00) & ~timersHalted
		& (~periodicPrescale | tick); // [R10]
	assign perEvent    = perStep & (perCnt_r <= 8'h01);
	assign intAckCycle = bus.as & (bus.space == sic_pkg::FC_CPU);
	assign intAckLevel = bus.addr[3:1];
	assign perWins     = intAckCycle & perPend_r
		& (intAckLevel == periodicRequestLevel); // [R03]

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			perCnt_r         <= 8'h00;
			perPend_r        <= 1'b0;
			periodicIrqLevel <= 3'h0;
			vectorOut        <= 8'h00;
			vectorValid      <= 1'b0;
		end else begin
			if (periodicModulus == 8'h00) begin
				perCnt_r <= 8'h00; // [R10]
			end else if (perStep) begin
				perCnt_r <= perEvent ? periodicModulus : perCnt_r - 8'h01;
			end
			// A new period beats the acknowledge that clears it
			if (periodicRequestLevel == 3'h0) begin
				perPend_r <= 1'b0; // [R11]
			end else if (perEvent) begin
				perPend_r <= 1'b1;
			end else if (perWins) begin
				perPend_r <= 1'b0;
			end
			periodicIrqLevel <= perPend_r ? periodicRequestLevel : 3'h0; // [R11]
			vectorValid      <= perWins;
			if (perWins) begin
				vectorOut <= periodicVectorNumber; // [R11]
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < sic_pkg::NCS; i++) begin : g_cs
			sic_pkg::sic_cs_t cfg_r;
			logic [3:0]       wait_r;
			logic             selN_r;
			logic [12:0]      mask;
			logic [3:0]       target;
			logic             hit, spaceOk, dirOk, byteOk, strobeOk, match, autoCyc, selfAck;

			always_ff @(posedge mclk) begin
				if (!rstn) begin
					cfg_r <= (i == 0) ? sic_pkg::BOOT_RST : '0; // [R14]
				end else if (csWe[i]) begin
					cfg_r <= csWd;
				end
			end

			assign mask = sic_pkg::blkMask(cfg_r.blk);
			assign hit  = (((bus.addr[23:11] ^ cfg_r.base) & ~mask) == 13'h0000); // [R23]
			always_comb begin
				case (cfg_r.space)
					sic_pkg::SP_CPU: spaceOk = intAckCycle & (intAckLevel == cfg_r.level); // [R21]
					sic_pkg::SP_USER: spaceOk = (bus.space == sic_pkg::FC_USER);
					sic_pkg::SP_SUPER: spaceOk = (bus.space == sic_pkg::FC_SUPER);
					default: spaceOk = (bus.space == sic_pkg::FC_USER)
						| (bus.space == sic_pkg::FC_SUPER); // [R21]
				endcase
			end
			assign dirOk    = bus.rd ? cfg_r.dir[1] : cfg_r.dir[0]; // [R18]
			assign byteOk   = (bus.upper & cfg_r.byteSel[1]) | (bus.lower & cfg_r.byteSel[0]);
			assign strobeOk = (cfg_r.mode | ~cfg_r.strobeSel) ? bus.as : bus.ds; // [R17] [R19]
			// Periodic timer answers its own acknowledge, so selects stay off
			assign match    = hit & spaceOk & dirOk & byteOk & strobeOk & ~perWins; // [R23]
			// Autovector works whatever the pin assignment
			assign autoCyc  = match & (cfg_r.space == sic_pkg::SP_CPU) & cfg_r.autoVec; // [R13] [R22]
			assign target   = (cfg_r.ack == sic_pkg::ACK_FAST) ? 4'h0 : cfg_r.ack;
			assign selfAck  = match & cfg_r.pa[1] & ~autoCyc & ~bus.extAck
				& (cfg_r.mode ? slowFall
				: ((cfg_r.ack != sic_pkg::ACK_EXT) & (wait_r >= target))); // [R17] [R20]
			assign csAck8[i]     = selfAck & (cfg_r.pa == sic_pkg::PA_8BIT); // [R12]
			assign csAck16[i]    = selfAck & (cfg_r.pa == sic_pkg::PA_16BIT); // [R12]
			assign csAuto[i]     = autoCyc; // [R20]
			assign selectOutN[i] = selN_r;

			always_ff @(posedge mclk) begin
				if (!rstn) begin
					wait_r <= 4'h0;
					selN_r <= 1'b1;
				end else begin
					wait_r <= !match ? 4'h0 : (wait_r == 4'hF) ? wait_r : wait_r + 4'h1;
					case (cfg_r.pa)
						sic_pkg::PA_DISC: selN_r <= portCData[i]; // [R12]
						sic_pkg::PA_ALT: selN_r <= 1'b1; // [R12]
						default: selN_r <= ~match; // [R13]
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cycleAck          <= 2'h0;
			autovectorRequest <= 1'b0;
		end else begin
			cycleAck          <= {|csAck16, |csAck8}; // [R20]
			autovectorRequest <= |csAuto; // [R22]
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_svcArm;
		serviceWe && serviceData == sic_pkg::SVC_ARM;
	endsequence
	sequence s_svcDone;
		serviceWe && serviceData == sic_pkg::SVC_DONE;
	endsequence
	property p_wdService;
		s_svcArm ##1 s_svcDone |=> wdCnt_r == 16'h0000;
	endproperty
	a_wdService: assert property (p_wdService) else $error("service kept count"); // [R08]
	property p_wdFire;
		ctrl_r.wdEn && !timersHalted && !watchdogPrescale && wdCnt_r == wdLimit
			|=> systemReset && wdCnt_r == 16'h0000;
	endproperty
	a_wdFire: assert property (p_wdFire) else $error("watchdog no reset"); // [R08]
	property p_mapHi;
		bus.as && ctrl_r.mapSel && bus.addr[23:12] == sic_pkg::MAP_HI |=> regSelect;
	endproperty
	a_mapHi: assert property (p_mapHi) else $error("register block missed"); // [R01]
	property p_freeze;
		freeze && haltSoftwareTimersEnable |=> $stable(presc_r) && $stable(wdCnt_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("timers ran in freeze"); // [R02]
	property p_ctrlRst;
		$rose(rstn) |-> ctrl_r == sic_pkg::CTRL_RST && g_cs[0].cfg_r == sic_pkg::BOOT_RST;
	endproperty
	a_ctrlRst: assert property (p_ctrlRst) else $error("bad reset value"); // [R03]
	property p_perStop;
		periodicModulus == 8'h00 |=> perCnt_r == 8'h00;
	endproperty
	a_perStop: assert property (p_perStop) else $error("timer ran at zero"); // [R10]
	property p_perMask;
		periodicRequestLevel == 3'h0 [*2] |=> periodicIrqLevel == 3'h0;
	endproperty
	a_perMask: assert property (p_perMask) else $error("masked request seen"); // [R11]
	property p_limp;
		crystalLost && !crystalLossResetEnable |=> limpMode;
	endproperty
	a_limp: assert property (p_limp) else $error("limp mode missing"); // [R06]
	property p_stop;
		lowPowerStop && !stopSystemClockSelect |=> !sysClockRun;
	endproperty
	a_stop: assert property (p_stop) else $error("clock ran in stop"); // [R07]
	property p_alt;
		g_cs[2].cfg_r.pa == sic_pkg::PA_ALT |=> selectOutN[2];
	endproperty
	a_alt: assert property (p_alt) else $error("alternate pin driven"); // [R12]
	property p_auto;
		g_cs[2].autoCyc |=> autovectorRequest && !cycleAck[1];
	endproperty
	a_auto: assert property (p_auto) else $error("autovector missing"); // [R22]
endmodule : sic_top

// [tb/sic_mem_model.sv]
// Behavioural external memory that terminates its own cycles after an access time
`timescale 1ns/100ps
module sic_mem_model (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  wire logic [3:0] accessTime,
	input  wire logic       selectN,
	output logic            extAck
);
	logic [3:0] waitCnt_r;
	// Ack drops on the first clock edge after the select goes away, never held over into the next cycle
	always_ff @(posedge mclk) begin
		if (!rstn || selectN || !enable) begin
			waitCnt_r <= 4'h0;
			extAck    <= 1'b0;
		end else begin
			if (waitCnt_r != 4'hF)
				waitCnt_r <= waitCnt_r + 4'h1;
			extAck <= (waitCnt_r >= accessTime);
		end
	end
endmodule : sic_mem_model

// [tb/sic_top_bench.sv]
// Self-checking bench for the system integration block
`timescale 1ns/100ps
module sic_top_bench;
	logic               mclk, rstn, ctrlWe, freeze, haltSoftwareTimersEnable, synthX;
	logic               haltBusMonitorEnable, crystalLossResetEnable, crystalLost;
	logic               lowPowerStop, stopSystemClockSelect, stopExternalClockSelect;
	logic               slowClockDivider, watchdogPrescale, serviceWe, busMonitorEnable;
	logic               doubleFaultMonitorEnableA, doubleFaultMonitorEnableB, periodicPrescale;
	logic [1:0]         synthW, watchdogTimeoutSelect, busMonitorTimeout, cycleAck, ackKind;
	logic [5:0]         synthY;
	logic [7:0]         serviceData, periodicModulus, periodicVectorNumber, vectorOut, seenVec;
	logic [2:0]         periodicRequestLevel, periodicIrqLevel;
	logic [3:0]         csWe, portCData, arbitrationPriority, selectOutN, memDly;
	logic [11:0]        freqMult;
	logic               regSelect, systemReset, limpMode, sysClockRun, extClockRun;
	logic               slowPeripheralClockOut, busError, haltOut, vectorValid, autovectorRequest;
	logic               memEn, memAck, seenSel, seenAv, seenReg, slowPrev;
	sic_pkg::sic_ctrl_t ctrlWd;
	sic_pkg::sic_cs_t   csWd, cs1, cs2;
	sic_pkg::sic_bus_t  busDrv, busIn;
	int                 errors, checked, rstCnt, errCnt, slowRise, ackAt, holdLen;

	sic_top #(.WD_LOG2(2), .PRESC_TOP(9'h003)) dut (.mclk, .rstn, .ctrlWe, .ctrlWd, .freeze,
		.haltSoftwareTimersEnable, .haltBusMonitorEnable, .synthW, .synthX, .synthY,
		.crystalLossResetEnable, .crystalLost, .lowPowerStop, .stopSystemClockSelect,
		.stopExternalClockSelect, .slowClockDivider, .watchdogPrescale, .watchdogTimeoutSelect,
		.serviceWe, .serviceData, .busMonitorEnable, .busMonitorTimeout,
		.doubleFaultMonitorEnableA, .doubleFaultMonitorEnableB, .periodicModulus,
		.periodicPrescale, .periodicRequestLevel, .periodicVectorNumber, .csWe, .csWd,
		.portCData, .bus(busIn), .regSelect, .arbitrationPriority, .freqMult, .systemReset,
		.limpMode, .sysClockRun, .extClockRun, .slowPeripheralClockOut, .busError, .haltOut,
		.periodicIrqLevel, .vectorOut, .vectorValid, .selectOutN, .cycleAck, .autovectorRequest);

	sic_mem_model mem (.mclk, .rstn, .enable(memEn), .accessTime(memDly),
		.selectN(selectOutN[1]), .extAck(memAck));

	always_comb begin
		busIn = busDrv;
		busIn.extAck = memAck;
	end

	// Sampled on the rising edge so that clearing at the falling edge never races
	always @(posedge mclk) begin
		rstCnt += (systemReset === 1'b1);
		errCnt += (busError === 1'b1);
		slowRise += (slowPeripheralClockOut === 1'b1 && slowPrev === 1'b0);
		slowPrev = slowPeripheralClockOut;
	end

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic close_out;
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask : done

	task automatic wrCtrl(input sic_pkg::sic_ctrl_t v);
		@(negedge mclk);
		ctrlWe = 1'b1;
		ctrlWd = v;
		@(negedge mclk);
		ctrlWe = 1'b0;
	endtask : wrCtrl

	task automatic wrCs(input int ch, input sic_pkg::sic_cs_t v);
		@(negedge mclk);
		csWe = 4'h1 << ch;
		csWd = v;
		@(negedge mclk);
		csWe = 4'h0;
	endtask : wrCs

	task automatic svc;
		@(negedge mclk);
		serviceWe = 1'b1;
		serviceData = sic_pkg::SVC_ARM;
		@(negedge mclk);
		serviceData = sic_pkg::SVC_DONE;
		@(negedge mclk);
		serviceWe = 1'b0;
	endtask : svc

	// One bus cycle, f = {read, upper, lower, data strobe}; records what channel ch did
	task automatic cyc(input logic [23:0] a, input logic [3:0] f, input logic [1:0] sp,
			input int ch);
		@(negedge mclk);
		busDrv = '{a, 1'b1, f[0], f[3], f[2], f[1], sp, 1'b0};
		{seenSel, seenAv, seenReg} = 3'h0;
		seenVec = 8'h00;
		ackAt = 0;
		ackKind = 2'h0;
		for (int i = 1; i <= holdLen; i++) begin
			@(negedge mclk);
			if (selectOutN[ch] === 1'b0) seenSel = 1'b1;
			if (autovectorRequest === 1'b1) seenAv = 1'b1;
			if (regSelect === 1'b1) seenReg = 1'b1;
			if (vectorValid === 1'b1) seenVec = vectorOut;
			if (ackAt == 0 && cycleAck !== 2'h0) begin
				ackAt = i;
				ackKind = cycleAck;
			end
		end
		busDrv.as = 1'b0;
		busDrv.ds = 1'b0;
		tick(2);
	endtask : cyc

	task automatic freq(input logic [8:0] wxy, input logic [11:0] exp);
		{synthW, synthX, synthY} = wxy;
		tick(3);
		chk("freqMult", freqMult, exp);
	endtask : freq

	task automatic csRow(input logic [23:0] a, input logic [3:0] f, input logic [1:0] sp,
			input logic exp);
		cyc(a, f, sp, 1);
		chk("select1", seenSel, exp);
	endtask : csRow

	task automatic mon;
		cyc(24'h03_0010, 4'h5, sic_pkg::FC_SUPER, 1);
	endtask : mon

	// Tests need about 2100 cycles; this allows over nine times that
	initial begin
		#80000;
		errors++;
		close_out();
	end

	initial begin
		{ctrlWe, haltBusMonitorEnable, synthX, crystalLossResetEnable, crystalLost, lowPowerStop,
			stopSystemClockSelect, stopExternalClockSelect, slowClockDivider, watchdogPrescale,
			serviceWe, busMonitorEnable, doubleFaultMonitorEnableA, doubleFaultMonitorEnableB,
			periodicPrescale, memEn} = '0;
		{synthW, synthY, serviceData, periodicModulus, periodicVectorNumber,
			periodicRequestLevel, csWe, busMonitorTimeout, memDly} = '0;
		{ctrlWd, csWd, busDrv} = '0;
		{freeze, haltSoftwareTimersEnable, watchdogTimeoutSelect, portCData} = 8'hFF;
		holdLen = 20;
		rstn = 1'b0;
		tick(5);
		rstn = 1'b1;
		tick(1);
		chk("arbitration", arbitrationPriority, sic_pkg::ARB_RST);
		chk("selects", selectOutN, 4'hF);
		chk("clockRun", {sysClockRun, extClockRun}, 2'h3);
		done("reset");
		rstCnt = 0;
		tick(400);
		chk("wdFrozen", rstCnt, 0);
		freeze = 1'b0;
		tick(300);
		chk("wdExpire", rstCnt > 0, 1);
		rstCnt = 0;
		repeat (4) begin
			svc();
			tick(100);
		end
		chk("wdServiced", rstCnt, 0);
		{watchdogTimeoutSelect, watchdogPrescale} = 3'h1;
		svc();
		rstCnt = 0;
		tick(6);
		chk("wdPrescaled", rstCnt, 0);
		tick(40);
		chk("wdPrescaleFire", rstCnt > 0, 1);
		wrCtrl('{1'b1, 1'b0, 4'h5});
		tick(2);
		rstCnt = 0;
		tick(100);
		chk("wdOff", rstCnt, 0);
		chk("arbWrite", arbitrationPriority, 4'h5);
		done("watchdog");
		freq({2'h0, 1'h0, 6'h00}, 12'h004);
		freq({2'h1, 1'h1, 6'h03}, 12'h080);
		freq({2'h2, 1'h0, 6'h07}, 12'h200);
		{crystalLossResetEnable, crystalLost} = 2'h3;
		tick(3);
		chk("xtalReset", systemReset, 1'b1);
		crystalLossResetEnable = 1'b0;
		tick(3);
		chk("xtalLimp", {systemReset, limpMode}, 2'h1);
		crystalLost = 1'b0;
		for (int d = 0; d < 2; d++) begin
			slowClockDivider = d[0];
			tick(32);
			slowRise = 0;
			tick(64);
			chk("slowClock", slowRise, d ? 4 : 8);
		end
		{lowPowerStop, stopSystemClockSelect, stopExternalClockSelect} = 3'h6;
		tick(3);
		chk("stopClocks", {sysClockRun, extClockRun}, 2'h2);
		lowPowerStop = 1'b0;
		done("clocks");
		for (int m = 0; m < 2; m++) begin
			wrCtrl('{m[0], 1'b0, 4'h5});
			cyc(24'hFF_F010, 4'hF, sic_pkg::FC_SUPER, 0);
			chk("regHigh", seenReg, m[0]);
			cyc(24'h7F_F010, 4'hF, sic_pkg::FC_SUPER, 0);
			chk("regLow", seenReg, !m[0]);
		end
		done("map");
		periodicVectorNumber = 8'h40;
		periodicModulus = 8'h04;
		tick(40);
		chk("pitMasked", periodicIrqLevel, 3'h0);
		periodicRequestLevel = 3'h5;
		tick(20);
		chk("pitLevel", periodicIrqLevel, 3'h5);
		periodicModulus = 8'h00;
		cyc(24'hFF_FFFA, 4'hF, sic_pkg::FC_CPU, 0);
		chk("pitVector", seenVec, 8'h40);
		tick(40);
		chk("pitStopped", periodicIrqLevel, 3'h0);
		{periodicPrescale, periodicModulus} = {1'b1, 8'h04};
		tick(20);
		chk("pitRuns", periodicIrqLevel, 3'h5);
		periodicRequestLevel = 3'h0;
		tick(3);
		chk("pitLevelOff", periodicIrqLevel, 3'h0);
		periodicModulus = 8'h00;
		done("periodic");
		cyc(24'h01_0000, 4'hF, sic_pkg::FC_SUPER, 0);
		chk("bootWait", {seenSel, ackAt[4:0], ackKind}, {1'b1, 5'd14, 2'h2});
		cyc(24'h10_0000, 4'hF, sic_pkg::FC_SUPER, 0);
		chk("bootOut", seenSel, 1'b0);
		cs1 = '{sic_pkg::PA_8BIT, 13'h0060, 3'h3, 1'b0, 2'h2, 2'h1, 1'b1, 4'h2,
			sic_pkg::SP_SUPER, 3'h0, 1'b0};
		wrCs(1, cs1);
		csRow(24'h03_0010, 4'h5, sic_pkg::FC_SUPER, 1'b1);
		chk("ackWait", {ackAt[4:0], ackKind}, {5'd3, 2'h1});
		csRow(24'h03_0010, 4'hD, sic_pkg::FC_SUPER, 1'b0);
		csRow(24'h03_0010, 4'h3, sic_pkg::FC_SUPER, 1'b0);
		csRow(24'h03_0010, 4'h4, sic_pkg::FC_SUPER, 1'b0);
		csRow(24'h03_0010, 4'h5, sic_pkg::FC_USER, 1'b0);
		csRow(24'h04_0010, 4'h5, sic_pkg::FC_SUPER, 1'b0);
		cs1.mode = 1'b1;
		wrCs(1, cs1);
		csRow(24'h03_0010, 4'h4, sic_pkg::FC_SUPER, 1'b1);
		for (int v = 0; v < 2; v++) begin
			portCData = {v[0], 3'h0};
			tick(3);
			chk("discrete", selectOutN[3], v[0]);
		end
		cs2 = '{sic_pkg::PA_ALT, 13'h1FFF, 3'h0, 1'b0, 2'h3, 2'h3, 1'b0, 4'h2,
			sic_pkg::SP_CPU, 3'h3, 1'b1};
		wrCs(2, cs2);
		cyc(24'hFF_F806, 4'hF, sic_pkg::FC_CPU, 2);
		chk("autovec", {seenAv, ackAt != 0}, 2'h2);
		cs2.pa = sic_pkg::PA_16BIT;
		cs2.autoVec = 1'b0;
		wrCs(2, cs2);
		cyc(24'hFF_F806, 4'hF, sic_pkg::FC_CPU, 2);
		chk("ackStrobe", {seenAv, seenSel}, 2'h1);
		cyc(24'hFF_F80A, 4'hF, sic_pkg::FC_CPU, 2);
		chk("ackLevel", seenSel, 1'b0);
		done("selects");
		cs1.mode = 1'b0;
		cs1.ack = sic_pkg::ACK_EXT;
		wrCs(1, cs1);
		{busMonitorEnable, busMonitorTimeout, memEn, memDly} = {1'b1, 2'h3, 1'b1, 4'h2};
		holdLen = 12;
		errCnt = 0;
		mon();
		chk("extTerm", {ackAt != 0, errCnt != 0}, 2'h0);
		memDly = 4'hA;
		mon();
		chk("slowTimeout", errCnt != 0, 1'b1);
		{memEn, freeze, haltBusMonitorEnable} = 3'h3;
		errCnt = 0;
		mon();
		chk("monFrozen", errCnt, 0);
		{freeze, doubleFaultMonitorEnableA} = 2'h1;
		mon();
		chk("firstFault", {errCnt != 0, haltOut}, 2'h2);
		mon();
		chk("doubleFault", haltOut, 1'b1);
		done("monitor");
		close_out();
	end
endmodule : sic_top_bench
